/* File: core/sll_pkg.sv */
// Package with constants and carrier types for the shift latch LED driver.
package sll_pkg;
  localparam int SLL_WIDTH = 8;
  localparam logic [7:0] SLL_SHIFT_RESET = 8'h00;
  localparam logic [7:0] SLL_LATCH_RESET = 8'h00;
  localparam logic [2:0] SLL_SYNC_RESET = 3'h0;
  localparam logic [2:0] SLL_OEN_SYNC_RESET = 3'h7;
  localparam logic SLL_LVL_RESET = 1'h0;
  localparam logic SLL_OEN_LVL_RESET = 1'h1;
  localparam logic SLL_CASCADE_RESET = 1'h0;
  localparam logic [7:0] SLL_SINK_RESET = 8'h00;
  localparam logic [7:0] SLL_SINK_OE_RESET = 8'h00;
  localparam int SLL_CASCADE_DELAY = 8;

  typedef struct packed {
    logic data;
    logic shift_clk;
    logic latch_load;
    logic out_enable_n;
  } sll_pins_type;

  typedef struct packed {
    logic [7:0] sink_out;
    logic [7:0] sink_oe;
  } sll_drive_type;
endpackage

/* File: core/sll_driver.sv */
// Shift register, output latch and open-drain sink drivers sampled on the system clock.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Each rising shift clock edge shifts the serial input into the 8-bit register.
// - While latch_load is high the latch follows the shift register.
// - Falling latch_load freezes the latch until latch_load rises again.
// - Output enable high releases all eight sinks and leaves the latch untouched.
// - Output enable low lets each sink follow its latch bit.
// - Each rising shift clock edge drives the last register bit to the cascade output.
// - Eight sink outputs, zero to seven, one per latch bit.
// - A serial input bit reaches the cascade output eight shift clocks later.
// - Shifting and latching ignore the output enable.
module sll_driver
  import sll_pkg::*;
#(
  parameter int WIDTH = SLL_WIDTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire sll_pins_type pins,
  output logic cascade_out,
  output logic [WIDTH-1:0] sink_outputs,
  output logic [WIDTH-1:0] sink_outputs_oe,
  output logic [WIDTH-1:0] latch_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filtered levels.

  logic [2:0] data_sync_reg, data_sync_next;
  logic [2:0] clk_sync_reg, clk_sync_next;
  logic [2:0] load_sync_reg, load_sync_next;
  logic [2:0] oen_sync_reg, oen_sync_next;
  logic data_lvl_reg, data_lvl_next;
  logic clk_lvl_reg, clk_lvl_next;
  logic load_lvl_reg, load_lvl_next;
  logic oen_lvl_reg, oen_lvl_next;

  function automatic logic sll_filter(input logic [2:0] s, input logic prev);
    sll_filter = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_comb begin
    data_sync_next = {data_sync_reg[1:0], pins.data};
    clk_sync_next = {clk_sync_reg[1:0], pins.shift_clk};
    load_sync_next = {load_sync_reg[1:0], pins.latch_load};
    oen_sync_next = {oen_sync_reg[1:0], pins.out_enable_n};
    data_lvl_next = sll_filter(data_sync_reg, data_lvl_reg);
    clk_lvl_next = sll_filter(clk_sync_reg, clk_lvl_reg);
    load_lvl_next = sll_filter(load_sync_reg, load_lvl_reg);
    oen_lvl_next = sll_filter(oen_sync_reg, oen_lvl_reg);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      data_sync_reg <= SLL_SYNC_RESET;
      clk_sync_reg <= SLL_SYNC_RESET;
      load_sync_reg <= SLL_SYNC_RESET;
      oen_sync_reg <= SLL_OEN_SYNC_RESET;
      data_lvl_reg <= SLL_LVL_RESET;
      clk_lvl_reg <= SLL_LVL_RESET;
      load_lvl_reg <= SLL_LVL_RESET;
      oen_lvl_reg <= SLL_OEN_LVL_RESET;
    end else begin
      data_sync_reg <= data_sync_next;
      clk_sync_reg <= clk_sync_next;
      load_sync_reg <= load_sync_next;
      oen_sync_reg <= oen_sync_next;
      data_lvl_reg <= data_lvl_next;
      clk_lvl_reg <= clk_lvl_next;
      load_lvl_reg <= load_lvl_next;
      oen_lvl_reg <= oen_lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and cascade output.

  logic shift_edge;
  logic [WIDTH-1:0] shift_reg, shift_next;
  logic cascade_reg, cascade_next;

  function automatic logic sll_rise(input logic now_lvl, input logic old_lvl);
    sll_rise = now_lvl & ~old_lvl;
  endfunction

  assign shift_edge = sll_rise(clk_lvl_next, clk_lvl_reg);

  always_comb begin
    shift_next = shift_reg;
    cascade_next = cascade_reg;
    if (shift_edge) begin
      shift_next = {shift_reg[WIDTH-2:0], data_lvl_reg};
      cascade_next = shift_reg[WIDTH-1];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      shift_reg <= SLL_SHIFT_RESET;
      cascade_reg <= SLL_CASCADE_RESET;
    end else begin
      shift_reg <= shift_next;
      cascade_reg <= cascade_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch.

  logic [WIDTH-1:0] latch_reg, latch_next;

  always_comb begin
    latch_next = load_lvl_reg ? shift_reg : latch_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      latch_reg <= SLL_LATCH_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain sink drivers.

  logic [WIDTH-1:0] sink_reg, sink_next;
  logic [WIDTH-1:0] sink_oe_reg, sink_oe_next;

  always_comb begin
    sink_oe_next = oen_lvl_reg ? '0 : latch_reg;
    sink_next = '0;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sink_reg <= SLL_SINK_RESET;
      sink_oe_reg <= SLL_SINK_OE_RESET;
    end else begin
      sink_reg <= sink_next;
      sink_oe_reg <= sink_oe_next;
    end
  end

  assign cascade_out = cascade_reg;
  assign sink_outputs = sink_reg;
  assign sink_outputs_oe = sink_oe_reg;
  assign latch_state = latch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  property p_shift;
    @(posedge mclk) disable iff (srst)
      shift_edge |=> shift_reg[0] == $past(data_lvl_reg)
        && shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("Shift register did not shift.");

  property p_transparent;
    @(posedge mclk) disable iff (srst) load_lvl_reg |=> latch_reg == $past(shift_reg);
  endproperty
  a_transparent: assert property (p_transparent) else $error("Latch not transparent.");

  property p_hold;
    @(posedge mclk) disable iff (srst) !load_lvl_reg |=> $stable(latch_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("Latch changed while closed.");

  property p_capture;
    @(posedge mclk) disable iff (srst) $fell(load_lvl_reg) |-> latch_reg == $past(shift_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("Latch missed the closing copy.");

  property p_hiz;
    @(posedge mclk) disable iff (srst) oen_lvl_reg |=> sink_outputs_oe == '0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("Sink driven while disabled.");

  property p_follow;
    @(posedge mclk) disable iff (srst) !oen_lvl_reg |=> sink_outputs_oe == $past(latch_reg);
  endproperty
  a_follow: assert property (p_follow) else $error("Sink does not follow latch.");

  property p_cascade;
    @(posedge mclk) disable iff (srst) shift_edge |=> cascade_out == $past(shift_reg[WIDTH-1]);
  endproperty
  a_cascade: assert property (p_cascade) else $error("Cascade output wrong.");

  property p_cascade_still;
    @(posedge mclk) disable iff (srst) !shift_edge |=> $stable(cascade_out) && $stable(shift_reg);
  endproperty
  a_cascade_still: assert property (p_cascade_still) else $error("Shift without edge.");

  property p_sink_low;
    @(posedge mclk) disable iff (srst) sink_outputs == '0;
  endproperty
  a_sink_low: assert property (p_sink_low) else $error("Sink drives high.");

  c_shift: cover property (@(posedge mclk) disable iff (srst) shift_edge);
  c_close: cover property (@(posedge mclk) disable iff (srst) $fell(load_lvl_reg));
  c_drive: cover property (@(posedge mclk) disable iff (srst) sink_outputs_oe != '0);
  c_open: cover property (@(posedge mclk) disable iff (srst) sll_rise(load_lvl_next, load_lvl_reg));
  c_shift_off: cover property (@(posedge mclk) disable iff (srst) shift_edge && oen_lvl_reg);

  property p_filter_clk;
    @(posedge mclk) disable iff (srst)
      clk_sync_reg[1] == clk_sync_reg[2] |=> clk_lvl_reg == $past(clk_sync_reg[2]);
  endproperty
  a_filter_clk: assert property (p_filter_clk) else $error("Clock level not taken.");

  property p_glitch_clk;
    @(posedge mclk) disable iff (srst) clk_sync_reg[1] != clk_sync_reg[2] |=> $stable(clk_lvl_reg);
  endproperty
  a_glitch_clk: assert property (p_glitch_clk) else $error("Clock level moved early.");

  property p_filter_data;
    @(posedge mclk) disable iff (srst)
      data_sync_reg[1] == data_sync_reg[2] |=> data_lvl_reg == $past(data_sync_reg[2]);
  endproperty
  a_filter_data: assert property (p_filter_data) else $error("Data level not taken.");

  property p_filter_load;
    @(posedge mclk) disable iff (srst)
      load_sync_reg[1] == load_sync_reg[2] |=> load_lvl_reg == $past(load_sync_reg[2]);
  endproperty
  a_filter_load: assert property (p_filter_load) else $error("Load level not taken.");

endmodule
`default_nettype wire

/* File: test/sll_host.sv */
// Host controller model driving the serial pins.
`timescale 1ns/10ps
`default_nettype none
module sll_host
  import sll_pkg::*;
(
  input wire logic mclk,
  output var sll_pins_type pins
);
  initial pins = '{1'b0, 1'b0, 1'b0, 1'b1};
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic shift_bit(input logic b);
    pins.data <= b;
    idle(6);
    pins.shift_clk <= 1'b1;
    idle(6);
    pins.shift_clk <= 1'b0;
    pins.data <= ~b;
    idle(6);
  endtask
  task automatic drive_latch(input logic v);
    pins.latch_load <= v;
    idle(8);
  endtask
  task automatic set_oe(input logic v);
    pins.out_enable_n <= v;
    idle(8);
  endtask
endmodule
`default_nettype wire

/* File: test/test_sll_driver.sv */
// Self-checking testbench for the shift latch LED driver.
`timescale 1ns/10ps
`default_nettype none
module test_sll_driver;
  import sll_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  sll_pins_type pins;
  logic cascade_out;
  logic [7:0] sink_outputs, sink_outputs_oe, latch_state;
  logic [7:0] sreg = 8'h00;
  logic [7:0] word;
  logic oe_n;
  int n_mismatch = 0;
  int tests_run = 0;
  always #4 mclk = ~mclk;
  sll_host u_host (.mclk(mclk), .pins(pins));
  sll_driver #(.WIDTH(SLL_WIDTH)) u_dut (.mclk(mclk), .srst(srst), .pins(pins),
    .cascade_out(cascade_out), .sink_outputs(sink_outputs),
    .sink_outputs_oe(sink_outputs_oe), .latch_state(latch_state));
  function automatic logic [7:0] exp_oe(input logic [7:0] lat, input logic dis);
    return dis ? 8'h00 : lat;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h85b0));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    u_host.idle(4);
    for (int i = 0; i < 10; i++) begin
      word = i == 0 ? 8'hff : i == 1 ? 8'h00 : i == 2 ? 8'h80 : i == 3 ? 8'h01 : 8'($urandom);
      oe_n = (i < 2) ? 1'(i) : 1'($urandom);
      u_host.set_oe(oe_n);
      for (int k = 7; k >= 0; k--) begin
        u_host.shift_bit(word[k]);
        check({7'h00, cascade_out}, {7'h00, sreg[7]});
        sreg = {sreg[6:0], word[k]};
      end
      u_host.drive_latch(1'b1);
      check(latch_state, sreg);
      u_host.drive_latch(1'b0);
      u_host.shift_bit(~word[7]);
      sreg = {sreg[6:0], ~word[7]};
      check(latch_state, word);
      check(sink_outputs_oe, exp_oe(word, oe_n));
      check(sink_outputs, 8'h00);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
`default_nettype wire
